// ==== common/axis_status_pkg.sv ====
package axis_status_pkg;
    // Byte addresses of the registers (printed offsets are word indices)
    localparam logic [7:0] IDX_ACK        = 8'h01;
    localparam logic [7:0] IDX_STATUS     = 8'h02;
    localparam logic [7:0] ADDR_ACK       = 8'h04;   // 4 * IDX_ACK
    localparam logic [7:0] ADDR_STATUS    = 8'h08;   // 4 * IDX_STATUS
    localparam logic [7:0] ADDR_CTRL      = 8'h0c;
    localparam logic [7:0] ADDR_EVT       = 8'h10;
    localparam logic [7:0] ADDR_EVT_EN    = 8'h14;
    localparam logic [7:0] ADDR_EVT_CLR   = 8'h18;
    localparam logic [7:0] ADDR_CMD       = 8'h1c;
    // Command status bit positions
    localparam int BIT_BUSY      = 0;
    localparam int BIT_JOG_OK    = 1;
    localparam int BIT_DIRECT_OK = 2;
    localparam int BIT_STOP_IN   = 4;
    localparam int BIT_GRP_STOP  = 5;
    localparam int BIT_ALL_STOP  = 6;
    localparam int BIT_PTP_ACK   = 7;
    localparam int BIT_START_BAD = 8;
    localparam int BIT_DEVR_BAD  = 9;
    localparam int BIT_STOP_DONE = 12;
    localparam int BIT_POS_DONE  = 13;
    localparam int BIT_LATCH_ACK = 15;
    // Command register bits (write pulses)
    localparam int CMD_START     = 0;
    localparam int CMD_PTP       = 1;
    localparam int CMD_DEVR      = 2;
    localparam int CMD_LATCH_CLR = 3;
    localparam int CMD_STOP      = 4;
    // Control register bits
    localparam int CTRL_MEMOP    = 0;
    localparam int CTRL_ASSIGNED = 1;
    // Event bits: 0 stop executed, 1 positioning done, 2 start refused
    localparam int EVT_W = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0002;
endpackage

// ==== src/axis_command_status_flags.sv ====
// Notes on behaviour
// - Bit 15 of ack word sets when latch-flag clear request is accepted.
// - Busy bit 0 is high while the axis performs any operation.
// - In memory operation, unassigned axes show busy even when idle.
// - Bit 1 high whenever a jog command would be accepted.
// - Bit 2 high whenever a direct operation command would be accepted.
// - Stop-input bit 4 on stop command, emergency or deceleration input.
// - While stop-input is high, every other start command is refused.
// - Bit 5 on accepted group stop once stopped, and while request set.
// - Bit 6 on accepted all-unit stop once stopped, and while request set.
// - Bit 7 acknowledges an accepted high-speed point-to-point start.
// - Bit 8 set when an axis command cannot be accepted.
// - Bit 9 set when a deviation counter reset cannot be accepted.
// - Bit 12 set when manual/direct motion halts by decel, reset, unlock.
// - Bit 12 also set when manual/direct motion halts through an error.
// - Bit 13 set when direct positioning, origin search or return finishes.
// - Bit 13 also set when direct-operation jogging stops.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module axis_command_status_flags
    import axis_status_pkg::*;
(
    input  wire logic        clk,          // 40 MHz clock
    input  wire logic        nrst,         // Async reset, active low
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB access phase
    input  wire logic        pwrite,       // APB direction
    input  wire logic [7:0]  paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic      [31:0] prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error
    input  wire logic        axisMoving,   // Axis performs an operation
    input  wire logic        directMode,   // Motion is direct operation
    input  wire logic        manualMode,   // Motion is manual operation
    input  wire logic        jogActive,    // Jogging in progress
    input  wire logic        errorPresent, // Axis error active
    input  wire logic        stopCmd,      // Immediate/decel stop accepted
    input  wire logic        emgInput,     // Emergency stop input
    input  wire logic        decelInput,   // Deceleration input
    input  wire logic        grpStopReq,   // Group stop request in sync data
    input  wire logic        allStopReq,   // All-unit stop request in sync data
    input  wire logic        haltDecel,    // Halted: decel stop (pulse)
    input  wire logic        haltDevReset, // Halted: deviation reset (pulse)
    input  wire logic        haltUnlock,   // Halted: servo unlocked (pulse)
    input  wire logic        haltError,    // Halted: error (pulse)
    input  wire logic        moveDone,     // Positioning/origin move done (pulse)
    input  wire logic        devResetBusy, // Deviation reset cannot be taken
    output logic             startAccept,  // Accepted start, one cycle
    output logic             irq           // Level interrupt
);
    import axis_status_pkg::*;

    // Word registers and their next values; every register below has one
    // combinational next-state source, except jogMotionPrev, which samples jogActive
    // directly; all are only registered in the single clocked process further down.
    logic [15:0] ackWord, next_ackWord;
    logic [15:0] status, next_status;
    logic [15:0] ctrl, next_ctrl;
    logic [EVT_W-1:0] evt, next_evt;
    logic [EVT_W-1:0] evtEn, next_evtEn;
    logic        grpLatched, next_grpLatched;
    logic        allLatched, next_allLatched;
    logic        next_startAccept;
    logic [31:0] next_prdata;
    logic        wrStrobe, rdStrobe, cmdWr, mapped;
    logic        stopIn, busy, stopDone, posDone, startBad;
    logic        jogMotionPrev;

    // APB: single wait-free access, unmapped addresses answer with pslverr.
    // Ready is tied high, so a transfer always takes two cycles; the cost
    // is that read data must already stand when the access phase begins.
    assign wrStrobe = psel && penable && pwrite;
    assign rdStrobe = psel && penable && !pwrite;
    assign pready   = 1'b1;
    assign mapped   = (paddr == ADDR_ACK) || (paddr == ADDR_STATUS)
                   || (paddr == ADDR_CTRL) || (paddr == ADDR_EVT)
                   || (paddr == ADDR_EVT_EN) || (paddr == ADDR_EVT_CLR)
                   || (paddr == ADDR_CMD);
    assign pslverr  = psel && penable && !mapped;
    assign cmdWr    = wrStrobe && (paddr == ADDR_CMD);

    // Live conditions derived from the axis inputs
    // stop input sources
    assign stopIn   = stopCmd || emgInput || decelInput;
    // busy during motion; unassigned axes busy in memory operation
    assign busy     = axisMoving || (ctrl[CTRL_MEMOP] && !ctrl[CTRL_ASSIGNED]);
    // stop causes, error stop, only in manual or direct operation.
    // An error halt counts only while the error is present, so a stray
    // halt pulse without an error cannot raise the stop-executed flag.
    assign stopDone = (manualMode || directMode)
                   && (haltDecel || haltDevReset || haltUnlock
                       || (haltError && errorPresent));
    // move finished in direct operation, jog stopped in direct mode
    assign posDone  = directMode && (moveDone || (jogMotionPrev && !jogActive));
    // starts refused while stop input is high; also when busy
    assign startBad = cmdWr && (pwdata[CMD_START] || pwdata[CMD_PTP])
                   && (stopIn || busy);

    // Status word, acknowledge word, sync stop latches and events.
    // Live bits are recomputed every cycle; sticky bits are carried over
    // explicitly, and a set in the same cycle as a clear always wins.
    always_comb begin
        next_ackWord    = ackWord;
        next_status     = '0;
        next_grpLatched = grpLatched;
        next_allLatched = allLatched;
        next_startAccept = 1'b0;
        next_evt        = evt;
        if (cmdWr && pwdata[CMD_LATCH_CLR])
            next_ackWord[BIT_LATCH_ACK] = 1'b1;
        else if (cmdWr)
            next_ackWord[BIT_LATCH_ACK] = 1'b0;
        // group stop latched until axis is stopped and request released
        if (grpStopReq)
            next_grpLatched = 1'b1;
        else if (!axisMoving)
            next_grpLatched = 1'b0;
        if (allStopReq)
            next_allLatched = 1'b1;
        else if (!axisMoving)
            next_allLatched = 1'b0;
        next_status[BIT_BUSY]      = busy;
        // jogging possible when idle and no stop input
        next_status[BIT_JOG_OK]    = !busy && !stopIn;
        next_status[BIT_DIRECT_OK] = !busy && !stopIn;
        next_status[BIT_STOP_IN]   = stopIn;
        next_status[BIT_GRP_STOP]  = grpStopReq || (grpLatched && !axisMoving);
        next_status[BIT_ALL_STOP]  = allStopReq || (allLatched && !axisMoving);
        // Sticky flags hold until the next command write
        if (!cmdWr) begin
            next_status[BIT_PTP_ACK]   = status[BIT_PTP_ACK];
            next_status[BIT_START_BAD] = status[BIT_START_BAD];
            next_status[BIT_DEVR_BAD]  = status[BIT_DEVR_BAD];
        end
        if (cmdWr && pwdata[CMD_PTP] && !startBad)
            next_status[BIT_PTP_ACK] = 1'b1;
        if (startBad)
            next_status[BIT_START_BAD] = 1'b1;
        if (cmdWr && pwdata[CMD_DEVR] && (devResetBusy || stopIn))
            next_status[BIT_DEVR_BAD] = 1'b1;
        if (cmdWr && (pwdata[CMD_START] || pwdata[CMD_PTP]) && !startBad)
            next_startAccept = 1'b1;
        // Stop and done flags clear on a new start, set wins
        next_status[BIT_STOP_DONE] = status[BIT_STOP_DONE] && !next_startAccept;
        next_status[BIT_POS_DONE]  = status[BIT_POS_DONE] && !next_startAccept;
        if (stopDone)
            next_status[BIT_STOP_DONE] = 1'b1;
        if (posDone)
            next_status[BIT_POS_DONE] = 1'b1;
        // Interrupt events: clear register, set wins over clear
        if (wrStrobe && paddr == ADDR_EVT_CLR)
            next_evt = evt & ~pwdata[EVT_W-1:0];
        next_evt = next_evt | {startBad, posDone, stopDone};
    end

    // Software registers; status word is read-only, writes dropped
    always_comb begin
        next_ctrl  = ctrl;
        next_evtEn = evtEn;
        if (wrStrobe && paddr == ADDR_CTRL)
            next_ctrl = {14'h0000, pwdata[1:0]};
        if (wrStrobe && paddr == ADDR_EVT_EN)
            next_evtEn = pwdata[EVT_W-1:0];
    end

    // Read data mux, registered so it is valid in the access phase.
    // Loaded in the setup cycle only; outside a read it returns to zero,
    // so a stale word never lingers on the bus.
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_ACK:    next_prdata = {16'h0000, ackWord};
                ADDR_STATUS: next_prdata = {16'h0000, status};
                ADDR_CTRL:   next_prdata = {16'h0000, ctrl};
                ADDR_EVT:    next_prdata = {29'h0, evt};
                ADDR_EVT_EN: next_prdata = {29'h0, evtEn};
                default:     next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Level interrupt; stays high until software clears the event bit or its enable bit
    assign irq = |(evt & evtEn);

    // State registers; the reset branch loads constants only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ackWord       <= 16'h0000;
            status        <= 16'h0000;
            ctrl          <= CTRL_RESET;
            evt           <= '0;
            evtEn         <= '0;
            grpLatched    <= 1'b0;
            allLatched    <= 1'b0;
            startAccept   <= 1'b0;
            jogMotionPrev <= 1'b0;
            prdata        <= 32'h0000_0000;
        end else begin
            ackWord       <= next_ackWord;
            status        <= next_status;
            ctrl          <= next_ctrl;
            evt           <= next_evt;
            evtEn         <= next_evtEn;
            grpLatched    <= next_grpLatched;
            allLatched    <= next_allLatched;
            startAccept   <= next_startAccept;
            jogMotionPrev <= jogActive;
            prdata        <= next_prdata;
        end
    end

    // Checks below on the status, ack and event words watch them one cycle after their cause,
    // matching the single register stage between inputs and the status word.

    // stop input flag
    // Mirrors its sources one cycle later
    chk_stop_input: assert property (@(posedge clk) disable iff (!nrst)
        (emgInput || decelInput || stopCmd) |=> status[BIT_STOP_IN])
        else $error("stop input flag missing");

    // starts refused in stop
    // A refused start must neither pulse nor stay silent
    chk_start_refused: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && pwdata[CMD_START] && stopIn) |=> !startAccept && status[BIT_START_BAD])
        else $error("start accepted during stop input");

    // no ack in stop
    // The high-speed start is refused like any other start
    chk_ptp_refused: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && pwdata[CMD_PTP] && stopIn) |=> !status[BIT_PTP_ACK])
        else $error("ptp acknowledged during stop input");

    chk_busy_moving: assert property (@(posedge clk) disable iff (!nrst)
        axisMoving |=> status[BIT_BUSY])
        else $error("busy not shown while moving");

    // unassigned axis busy
    // Memory operation with the axis left out of the configuration
    chk_busy_unassigned: assert property (@(posedge clk) disable iff (!nrst)
        (ctrl[CTRL_MEMOP] && !ctrl[CTRL_ASSIGNED]) |=> status[BIT_BUSY])
        else $error("unassigned axis not busy");

    // jog enable blocked
    // Enable must never show while a stop or motion blocks a start
    chk_jog_enable: assert property (@(posedge clk) disable iff (!nrst)
        status[BIT_JOG_OK] |-> !$past(stopIn) && !$past(busy))
        else $error("jog enabled while blocked");

    chk_jog_blocked: assert property (@(posedge clk) disable iff (!nrst)
        stopIn |=> !status[BIT_JOG_OK])
        else $error("jog enable shown during stop input");

    chk_direct_enable: assert property (@(posedge clk) disable iff (!nrst)
        (!busy && !stopIn) |=> status[BIT_DIRECT_OK])
        else $error("direct enable missing");

    chk_group_stop: assert property (@(posedge clk) disable iff (!nrst)
        grpStopReq |=> status[BIT_GRP_STOP])
        else $error("group stop flag missing");

    chk_all_stop: assert property (@(posedge clk) disable iff (!nrst)
        allStopReq |=> status[BIT_ALL_STOP])
        else $error("all stop flag missing");

    chk_ptp_ack: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && pwdata[CMD_PTP] && !stopIn && !busy) |=> status[BIT_PTP_ACK])
        else $error("ptp start not acknowledged");

    // start refused when busy
    // Busy refusal is our choice; it uses the same flag as a stop refusal
    chk_start_busy: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && pwdata[CMD_START] && busy) |=> status[BIT_START_BAD] && !startAccept)
        else $error("start accepted while busy");

    chk_devr_refused: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && pwdata[CMD_DEVR] && devResetBusy) |=> status[BIT_DEVR_BAD])
        else $error("deviation reset refusal missing");

    chk_stop_causes: assert property (@(posedge clk) disable iff (!nrst)
        ((manualMode || directMode) && (haltDecel || haltDevReset || haltUnlock))
        |=> status[BIT_STOP_DONE])
        else $error("stop executed missing for halt");

    // no flag outside modes
    // Automatic operation halts must not raise stop executed
    chk_stop_mode: assert property (@(posedge clk) disable iff (!nrst)
        (!manualMode && !directMode && !status[BIT_STOP_DONE]) |=> !status[BIT_STOP_DONE])
        else $error("stop executed outside manual or direct");

    // error stop flagged
    // Also raises the stop-executed event for the interrupt
    chk_stop_done: assert property (@(posedge clk) disable iff (!nrst)
        (directMode && haltError && errorPresent) |=> status[BIT_STOP_DONE] && evt[0])
        else $error("stop executed missing");

    chk_pos_done: assert property (@(posedge clk) disable iff (!nrst)
        directMode && moveDone |=> status[BIT_POS_DONE])
        else $error("positioning done missing");

    chk_pos_mode: assert property (@(posedge clk) disable iff (!nrst)
        (!directMode && !status[BIT_POS_DONE]) |=> !status[BIT_POS_DONE])
        else $error("positioning done outside direct");

    // jog stop completes
    // Falling edge of jogging seen against its previous sample
    chk_jog_stop_done: assert property (@(posedge clk) disable iff (!nrst)
        (directMode && $past(jogActive) && !jogActive) |=> status[BIT_POS_DONE])
        else $error("jog stop not completed");

    chk_latch_ack: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && pwdata[CMD_LATCH_CLR]) |=> ackWord[BIT_LATCH_ACK])
        else $error("latch clear not acknowledged");

    chk_latch_drop: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && !pwdata[CMD_LATCH_CLR]) |=> !ackWord[BIT_LATCH_ACK])
        else $error("latch clear ack not dropped");

    chk_ack_readonly: assert property (@(posedge clk) disable iff (!nrst)
        (wrStrobe && paddr == ADDR_ACK) |=> $stable(ackWord))
        else $error("ack word changed by host write");

    // Event set wins over a clear in the same cycle
    chk_evt_set_wins: assert property (@(posedge clk) disable iff (!nrst)
        (stopDone && wrStrobe && paddr == ADDR_EVT_CLR && pwdata[0]) |=> evt[0])
        else $error("event lost to clear");

    // Enabled event drives the interrupt
    chk_irq_level: assert property (@(posedge clk) disable iff (!nrst)
        (evt[0] && evtEn[0]) |-> irq)
        else $error("interrupt missing");

    // Addresses past the command register are unmapped
    chk_unmapped_err: assert property (@(posedge clk) disable iff (!nrst)
        (psel && penable && paddr > ADDR_CMD) |-> pslverr)
        else $error("unmapped access without error");

    // Upper half of every read is zero
    chk_read_upper: assert property (@(posedge clk) disable iff (!nrst)
        (psel && penable && !pwrite) |-> prdata[31:16] == 16'h0000)
        else $error("read upper half not zero");

    // Start pulse lasts one cycle
    chk_start_pulse: assert property (@(posedge clk) disable iff (!nrst)
        startAccept |=> !startAccept)
        else $error("start pulse too long");
endmodule // axis_command_status_flags

// ==== tb/axis_command_status_flags_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module axis_command_status_flags_tb_top;
    import axis_status_pkg::*;
    // reserved status bits not relied on
    localparam logic [31:0] DEFINED = 32'h000033f7;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, timedOut, e, sawAcc;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        axisMoving, directMode, manualMode, jogActive, errorPresent;
    logic        grpStopReq, allStopReq, devResetBusy, startAccept, irq;
    logic [2:0]  stops;    // Stop command, emergency, deceleration
    logic [4:0]  pulses;   // Four halt causes, then move done
    int          bad_count, n_compared, i;

    host_apb_model host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .timedOut(timedOut));
    axis_command_status_flags uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .axisMoving(axisMoving), .directMode(directMode),
        .manualMode(manualMode), .jogActive(jogActive), .errorPresent(errorPresent),
        .stopCmd(stops[0]), .emgInput(stops[1]), .decelInput(stops[2]),
        .grpStopReq(grpStopReq), .allStopReq(allStopReq), .haltDecel(pulses[0]),
        .haltDevReset(pulses[1]), .haltUnlock(pulses[2]), .haltError(pulses[3]),
        .moveDone(pulses[4]), .devResetBusy(devResetBusy), .startAccept(startAccept),
        .irq(irq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Catch the one-cycle start pulse, which is gone before a read could see it
    always @(posedge clk) if (startAccept === 1'b1) sawAcc <= 1'b1;
    // Whole-run limit
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, r, e);
    endtask
    // Status is read after its one-cycle update has landed
    task automatic st;
        repeat (2) @(posedge clk);
        rd(ADDR_STATUS);
    endtask
    task automatic cmd(input int b);
        sawAcc = 1'b0;
        wr(ADDR_CMD, 32'h1 << b);
    endtask
    task automatic pulse(input int b);
        pulses <= 5'h1 << b;
        @(posedge clk);
        pulses <= 5'h0;
    endtask
    task automatic wrap_up;
        if (timedOut === 1'b1) bad_count++;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        {nrst, axisMoving, directMode, manualMode, jogActive, errorPresent} = '0;
        {grpStopReq, allStopReq, devResetBusy, stops, pulses, sawAcc} = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(ADDR_CTRL);
        `CHK("ctrl reset", 32'h2, r)
        st;
        `CHK("status idle", 32'h6, r & DEFINED)
        wr(ADDR_STATUS, 32'hffff);
        st;
        `CHK("status write", 32'h6, r & DEFINED)
        rd(8'h20);
        `CHK("unmapped err", {1'b1, 32'h0}, {e, r})
        // Busy from motion, and a start refused while busy
        axisMoving <= 1'b1;
        st;
        `CHK("busy", 32'h1, r & 32'h7)
        cmd(CMD_START);
        st;
        `CHK("busy refuse", 2'b10, {r[8], sawAcc})
        axisMoving <= 1'b0;
        wr(ADDR_CTRL, 32'h1);
        st;
        `CHK("unassigned busy", 1'b1, r[0])
        wr(ADDR_CTRL, 32'h3);
        st;
        `CHK("assigned idle", 1'b0, r[0])
        wr(ADDR_CTRL, 32'h2);
        // Each stop source, then a start that must be refused
        for (i = 0; i < 3; i++) begin
            stops <= 3'h1 << i;
            st;
            `CHK("stop input", 32'h10, r & 32'h16)
            cmd((i == 0) ? CMD_START : CMD_PTP);
            st;
            `CHK("start in stop", 3'b100, {r[8], r[7], sawAcc})
        end
        stops <= 3'h0;
        cmd(CMD_PTP);
        st;
        `CHK("ptp ack", 3'b011, {r[8], r[7], sawAcc})
        devResetBusy <= 1'b1;
        cmd(CMD_DEVR);
        st;
        `CHK("devr refused", 1'b1, r[9])
        devResetBusy <= 1'b0;
        cmd(CMD_DEVR);
        st;
        `CHK("devr taken", 1'b0, r[9])
        cmd(CMD_LATCH_CLR);
        rd(ADDR_ACK);
        `CHK("latch ack", 32'h8000, r)
        cmd(CMD_START);
        rd(ADDR_ACK);
        `CHK("latch ack drop", 32'h0, r)
        grpStopReq <= 1'b1;
        st;
        `CHK("group stop", 1'b1, r[5])
        grpStopReq <= 1'b0;
        allStopReq <= 1'b1;
        st;
        `CHK("all stop", 1'b1, r[6])
        allStopReq <= 1'b0;
        // Each halt cause in manual operation, cleared by a fresh start
        wr(ADDR_EVT_EN, 32'h1);
        manualMode <= 1'b1;
        for (i = 0; i < 4; i++) begin
            errorPresent <= (i == 3);
            pulse(i);
            st;
            `CHK("stop done", 2'b11, {r[12], irq})
            wr(ADDR_EVT_CLR, 32'h1);
            cmd(CMD_START);
            st;
            `CHK("stop done clear", 2'b00, {r[12], irq})
        end
        pulse(0);
        wr(ADDR_EVT_EN, 32'h0);
        rd(ADDR_EVT);
        `CHK("irq masked", 2'b10, {r[0], irq})
        wr(ADDR_EVT_EN, 32'h1);
        `CHK("irq unmasked", 1'b1, irq)
        wr(ADDR_EVT_CLR, 32'h1);
        `CHK("irq cleared", 1'b0, irq)
        manualMode <= 1'b0;
        cmd(CMD_START);
        pulse(0);
        st;
        `CHK("halt no mode", 1'b0, r[12])
        directMode <= 1'b1;
        pulse(4);
        st;
        `CHK("move done", 1'b1, r[13])
        cmd(CMD_START);
        jogActive <= 1'b1;
        st;
        `CHK("jog running", 1'b0, r[13])
        jogActive <= 1'b0;
        st;
        `CHK("jog stopped", 1'b1, r[13])
        wrap_up;
    end
endmodule // axis_command_status_flags_tb_top

// ==== tb/host_apb_model.sv ====
`timescale 1ns/1ps
// Host controller side of the status words, acting as APB master
module host_apb_model (
    input  wire logic        clk,      // Bus clock
    input  wire logic [31:0] prdata,   // Read data
    input  wire logic        pready,   // Slave ready
    input  wire logic        pslverr,  // Slave error
    output logic             psel,     // Select
    output logic             penable,  // Access phase
    output logic             pwrite,   // Direction
    output logic [7:0]       paddr,    // Byte address
    output logic [31:0]      pwdata,   // Write data
    output logic             timedOut  // Ready never came
);
    // Idle bus at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata, timedOut} = '0;
    end
    // One transfer; the request stands until pready is seen at an edge or 16 edges pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) timedOut = 1'b1;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data must not keep showing the last value
        pwdata  <= ~d;
        @(posedge clk);
    endtask
endmodule // host_apb_model
